/* File: rtl/ssr_pkg.sv */
package ssr_pkg;

   // ------------------------------------------------------------------
   // status byte bit positions
   // ------------------------------------------------------------------
   localparam int SB_MEAS_BIT  = 0;
   localparam int SB_FREE_BIT  = 1;
   localparam int SB_ERR_BIT   = 2;
   localparam int SB_QUEST_BIT = 3;
   localparam int SB_MSG_BIT   = 4;
   localparam int SB_STD_BIT   = 5;
   localparam int SB_REQUEST_BIT = 6;
   localparam int SB_OPER_BIT  = 7;
   localparam int SB_WIDTH     = 8;

   // bits 0,2,3,4,5,7 take part in the master summary
   localparam logic [7:0] SB_SUMMARY_MASK = 8'hBD;
   localparam logic [7:0] SRE_RESET       = 8'h00;
   localparam logic [7:0] BYTE_ZERO       = 8'h00;

   // ------------------------------------------------------------------
   // enumerations
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      FMT_DEC = 2'h0,
      FMT_HEX = 2'h1,
      FMT_OCT = 2'h2,
      FMT_BIN = 2'h3
   } ssr_fmt_e;

   localparam ssr_fmt_e FMT_RESET = FMT_DEC;

   typedef enum logic [5:0] {
      CMD_NONE          = 6'h00,
      CMD_STB_QUERY     = 6'h01,
      CMD_SRE_WRITE     = 6'h02,
      CMD_SRE_QUERY     = 6'h04,
      CMD_CLEAR_STATUS  = 6'h08,
      CMD_STATUS_PRESET = 6'h10,
      CMD_FORMAT_SET    = 6'h20
   } ssr_cmd_e;

   typedef enum logic [2:0] {
      POLL_IDLE  = 3'h1,
      POLL_ARMED = 3'h2,
      POLL_SENT  = 3'h4
   } ssr_poll_e;

   // ------------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic operationSummary;
      logic standardEventSummary;
      logic outputMessageWaiting;
      logic questionableSummary;
      logic errorQueueNonempty;
      logic measSummary;
   } ssr_summary_s;

   typedef struct packed {
      logic     valid;
      ssr_cmd_e code;
      logic [7:0] data;
      ssr_fmt_e fmt;
   } ssr_cmd_s;

   typedef struct packed {
      logic start;
      logic talk;
      logic stop;
   } ssr_poll_s;

   typedef struct packed {
      logic     valid;
      ssr_fmt_e fmt;
      logic [7:0] data;
   } ssr_resp_s;

endpackage

/* File: rtl/ssr_status_byte.sv */
`timescale 1ns/100ps

module ssr_status_byte
   import ssr_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire ssr_summary_s summary,
   input  wire ssr_summary_s occurred,
   input  wire ssr_cmd_s     cmd,
   input  wire ssr_poll_s    poll,
   input  wire logic         srqIn,
   output ssr_resp_s         response,
   output logic [7:0]        pollByte,
   output logic              pollByteValid,
   output logic              srqOut,
   output logic              srqOe_n,
   output logic              clearEvents,
   output logic              presetEnables,
   output logic [7:0]        requestEnableMask,
   output logic              masterSummaryValue,
   output logic              requestServiceFlag,
   output logic              srqLineSeen
);

   // ------------------------------------------------------------------
   // live status byte
   // ------------------------------------------------------------------
   logic [7:0] statusByte;
   logic [7:0] occurVec;
   logic [7:0] maskedSummary;
   logic [7:0] maskedOccur;
   logic [7:0] maskedPrev;
   logic       liveMaster;

   assign statusByte[SB_MEAS_BIT]  = summary.measSummary;
   assign statusByte[SB_FREE_BIT]  = 1'h0;
   assign statusByte[SB_ERR_BIT]   = summary.errorQueueNonempty;
   assign statusByte[SB_QUEST_BIT] = summary.questionableSummary;
   assign statusByte[SB_MSG_BIT]   = summary.outputMessageWaiting;
   assign statusByte[SB_STD_BIT]   = summary.standardEventSummary;
   // bit 6 is filled in per reader, see the two images
   assign statusByte[SB_REQUEST_BIT] = 1'h0;
   assign statusByte[SB_OPER_BIT]  = summary.operationSummary;

   assign occurVec = {occurred.operationSummary, 1'h0, occurred.standardEventSummary,
                      occurred.outputMessageWaiting, occurred.questionableSummary,
                      occurred.errorQueueNonempty, 1'h0, occurred.measSummary};

   // and-or tree; mask keeps enable bit 6 out
   assign maskedSummary = statusByte & requestEnableMask & SB_SUMMARY_MASK;
   assign maskedOccur   = occurVec & requestEnableMask & SB_SUMMARY_MASK;
   // follows the enabled summary bits only, a poll never touches it
   assign liveMaster    = |maskedSummary;

   // ------------------------------------------------------------------
   // request raising
   // ------------------------------------------------------------------
   logic riseHit;
   logic occurHit;
   logic raiseRequest;

   // enabled summary going 0 to 1
   assign riseHit      = |(maskedSummary & ~maskedPrev);
   // a fresh occurrence re-requests even while the summary stays high
   assign occurHit     = |maskedOccur;
   assign raiseRequest = riseHit | occurHit;

   // ------------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------------
   logic cmdStbQuery;
   logic cmdSreWrite;
   logic cmdSreQuery;
   logic cmdClear;
   logic cmdPreset;
   logic cmdFormat;

   assign cmdStbQuery = cmd.valid && (cmd.code == CMD_STB_QUERY);
   assign cmdSreWrite = cmd.valid && (cmd.code == CMD_SRE_WRITE);
   assign cmdSreQuery = cmd.valid && (cmd.code == CMD_SRE_QUERY);
   assign cmdClear    = cmd.valid && (cmd.code == CMD_CLEAR_STATUS);
   assign cmdPreset   = cmd.valid && (cmd.code == CMD_STATUS_PRESET);
   assign cmdFormat   = cmd.valid && (cmd.code == CMD_FORMAT_SET);

   // ------------------------------------------------------------------
   // serial poll sequencing
   // ------------------------------------------------------------------
   ssr_poll_e  pollState;
   ssr_poll_e  next_pollState;
   logic       pollTake;
   logic [7:0] pollImage;

   // a byte only goes out between poll enable and poll disable
   assign pollTake = poll.talk && (pollState != POLL_IDLE) && !poll.stop;

   // poll image carries the request flag in bit 6
   assign pollImage = {statusByte[SB_OPER_BIT], requestServiceFlag,
                       statusByte[SB_STD_BIT:SB_MEAS_BIT]};

   always_comb begin
      case (pollState)
         POLL_IDLE: begin
            next_pollState = poll.start ? POLL_ARMED : POLL_IDLE;
         end
         POLL_ARMED: begin
            if (poll.stop) begin
               next_pollState = POLL_IDLE;
            end else if (poll.talk) begin
               next_pollState = POLL_SENT;
            end else begin
               next_pollState = POLL_ARMED;
            end
         end
         POLL_SENT: begin
            next_pollState = poll.stop ? POLL_IDLE : POLL_SENT;
         end
         default: begin
            next_pollState = POLL_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------------
   // request flag and line
   // ------------------------------------------------------------------
   logic next_requestServiceFlag;

   // poll read clears; set wins when both land together
   assign next_requestServiceFlag = raiseRequest | (requestServiceFlag & ~pollTake);

   // ------------------------------------------------------------------
   // enable register and format
   // ------------------------------------------------------------------
   logic [7:0] next_requestEnableMask;
   ssr_fmt_e   regFormat;
   ssr_fmt_e   next_regFormat;

   // full 8-bit write, radix already resolved upstream
   // a write of 0 clears it like any other value
   // clear-status and preset are not decoded here on purpose
   assign next_requestEnableMask = cmdSreWrite ? cmd.data : requestEnableMask;
   assign next_regFormat         = cmdFormat ? cmd.fmt : regFormat;

   // ------------------------------------------------------------------
   // responses
   // ------------------------------------------------------------------
   ssr_resp_s  next_response;
   logic [7:0] stbImage;

   // query image carries the live master summary in bit 6
   assign stbImage = {statusByte[SB_OPER_BIT], liveMaster,
                      statusByte[SB_STD_BIT:SB_MEAS_BIT]};

   // every register read is tagged with the chosen format
   assign next_response.valid = cmdStbQuery | cmdSreQuery;
   assign next_response.fmt   = regFormat;
   assign next_response.data  = cmdStbQuery ? stbImage :
                                cmdSreQuery ? requestEnableMask : BYTE_ZERO;

   // ------------------------------------------------------------------
   // line sampling: the pin is asynchronous to clk
   // ------------------------------------------------------------------
   logic srqMeta;
   logic srqSync;

   // line read back
   // two raw flops first; reset to the pulled-up idle level so no false sighting
   always_ff @(posedge clk) begin
      if (!nrst) begin
         srqMeta     <= 1'h1;
         srqSync     <= 1'h1;
         srqLineSeen <= 1'h0;
      end else begin
         srqMeta     <= srqIn;
         srqSync     <= srqMeta;
         srqLineSeen <= ~srqSync;
      end
   end

   // ------------------------------------------------------------------
   // state registers
   // ------------------------------------------------------------------
   // poll sequence state
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pollState <= POLL_IDLE;
      end else begin
         pollState <= next_pollState;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         maskedPrev         <= BYTE_ZERO;
         requestServiceFlag <= 1'h0;
      end else begin
         maskedPrev         <= maskedSummary;
         requestServiceFlag <= next_requestServiceFlag;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         requestEnableMask <= SRE_RESET;
      end else begin
         requestEnableMask <= next_requestEnableMask;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         regFormat <= FMT_RESET;
      end else begin
         regFormat <= next_regFormat;
      end
   end

   // ------------------------------------------------------------------
   // registered outputs
   // ------------------------------------------------------------------
   // query reply out
   always_ff @(posedge clk) begin
      if (!nrst) begin
         response <= '0;
      end else begin
         response <= next_response;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         pollByte      <= BYTE_ZERO;
         pollByteValid <= 1'h0;
      end else begin
         pollByteValid <= pollTake;
         if (pollTake) begin
            pollByte <= pollImage;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         masterSummaryValue <= 1'h0;
      end else begin
         masterSummaryValue <= liveMaster;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         clearEvents   <= 1'h0;
         presetEnables <= 1'h0;
      end else begin
         clearEvents   <= cmdClear;
         presetEnables <= cmdPreset;
      end
   end

   // open drain: low output enable means the line is pulled
   // same cycle as the flag, both flops load from next_requestServiceFlag
   always_ff @(posedge clk) begin
      if (!nrst) begin
         srqOut  <= 1'h0;
         srqOe_n <= 1'h1;
      end else begin
         srqOut  <= 1'h0;
         // drive while a request is pending; release after poll
         srqOe_n <= ~next_requestServiceFlag;
      end
   end

endmodule

/* File: testbench/ssr_sb_props.sv */
`timescale 1ns/100ps
module ssr_sb_props
   import ssr_pkg::*;
(
   input wire logic         clk,
   input wire logic         nrst,
   input wire ssr_summary_s summary,
   input wire ssr_summary_s occurred,
   input wire ssr_cmd_s     cmd,
   input wire ssr_poll_s    poll,
   input wire logic [7:0]   pollByte,
   input wire logic         pollByteValid,
   input wire logic         srqOe_n,
   input wire ssr_resp_s    response,
   input wire logic [7:0]   requestEnableMask,
   input wire logic         masterSummaryValue,
   input wire logic         requestServiceFlag
);
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   logic [5:0] hitPrev;
   logic       armed;
   wire logic [5:0] en  = {requestEnableMask[7], requestEnableMask[5:2], requestEnableMask[0]};
   wire logic [5:0] hit = summary & en;
   wire logic       live = |hit;
   wire logic       raise = (|(hit & ~hitPrev)) | (|(occurred & en));
   wire logic       take = armed & poll.talk & ~poll.stop;
   wire logic [7:0] img = {summary[5], live, summary[4:1], 1'h0, summary[0]};
   wire logic [7:0] pimg = {summary[5], requestServiceFlag, summary[4:1], 1'h0, summary[0]};
   wire logic       wr = cmd.valid && cmd.code == CMD_SRE_WRITE;
   // mask change counts as a rise, so the previous hit uses the mask too
   always_ff @(posedge clk) begin
      hitPrev <= nrst ? hit : 6'h00;
      armed <= (!nrst || poll.stop) ? 1'h0 : (poll.start | armed);
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_take;
      take;
   endsequence
   a_master_follows: assert property (nrst |=> masterSummaryValue == $past(live))
      else $error("master summary does not follow enabled summaries");
   a_raise_flag: assert property (raise |=> requestServiceFlag && !srqOe_n)
      else $error("enabled rise did not set request");
   a_poll_clears: assert property (s_take ##0 !raise |=> !requestServiceFlag && srqOe_n)
      else $error("poll did not clear request");
   a_poll_byte: assert property (s_take |=> pollByteValid && pollByte == $past(pimg))
      else $error("poll byte wrong");
   a_stb_reply: assert property (cmd.valid && cmd.code == CMD_STB_QUERY
      |=> response.valid && response.data == $past(img))
      else $error("status byte query wrong");
   a_sre_write: assert property (wr |=> requestEnableMask == $past(cmd.data))
      else $error("enable write lost");
   a_mask_hold: assert property (!wr |=> $stable(requestEnableMask))
      else $error("enable register changed");
   a_srq_pending: assert property (srqOe_n == !requestServiceFlag)
      else $error("service line does not match request");
   a_sre_reply: assert property (cmd.valid && cmd.code == CMD_SRE_QUERY
      |=> response.valid && response.data == $past(requestEnableMask))
      else $error("enable query wrong");
endmodule

/* File: testbench/ssr_bus_ctrl.sv */
`timescale 1ns/100ps
module ssr_bus_ctrl
   import ssr_pkg::*;
(
   input  wire logic clk,
   input  wire logic srqOut,
   input  wire logic srqOe_n,
   output ssr_poll_s poll,
   output logic      srqIn
);
   // ---------------------------------------------
   // controller side of the poll
   // ---------------------------------------------
   // pulled-up request line
   assign srqIn = srqOe_n ? 1'h1 : srqOut;
   initial poll = 3'h0;
   task automatic talk_byte();
      @(negedge clk);
      poll = 3'h4;
      @(negedge clk);
      poll = 3'h2;
      @(negedge clk);
      poll = 3'h0;
   endtask
   task automatic stop_poll();
      @(negedge clk);
      poll = 3'h1;
      @(negedge clk);
      poll = 3'h0;
   endtask
endmodule

/* File: testbench/ssr_status_byte_bench.sv */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("mismatch %s exp %h got %h", nm, e, g); end end
bind ssr_status_byte ssr_sb_props i_ssr_sb_props (
   .clk                (clk),
   .nrst               (nrst),
   .summary            (summary),
   .occurred           (occurred),
   .cmd                (cmd),
   .poll               (poll),
   .pollByte           (pollByte),
   .pollByteValid      (pollByteValid),
   .srqOe_n            (srqOe_n),
   .response           (response),
   .requestEnableMask  (requestEnableMask),
   .masterSummaryValue (masterSummaryValue),
   .requestServiceFlag (requestServiceFlag)
);
module ssr_status_byte_bench
   import ssr_pkg::*;
;
   // ---------------------------------------------
   // stimulus and checks
   // ---------------------------------------------
   logic         clk = 1'h0;
   logic         nrst = 1'h0;
   ssr_summary_s summary = 6'h00;
   ssr_summary_s occurred = 6'h00;
   ssr_cmd_s     cmd = '0;
   ssr_poll_s    poll;
   ssr_resp_s    response;
   logic [7:0]   pollByte, requestEnableMask;
   logic         srqIn, pollByteValid, srqOut, srqOe_n, clearEvents, presetEnables;
   logic         masterSummaryValue, requestServiceFlag, srqLineSeen;
   int           fail_count = 0;
   int           n_checks = 0;
   logic [7:0]   wv [3] = '{8'hFF, 8'h2C, 8'h00};
   logic [7:0]   bitv [6] = '{8'h01, 8'h04, 8'h08, 8'h10, 8'h20, 8'h80};
   always #25 clk = ~clk;
   ssr_status_byte i_ssr_status_byte (
      .clk                (clk),
      .nrst               (nrst),
      .summary            (summary),
      .occurred           (occurred),
      .cmd                (cmd),
      .poll               (poll),
      .srqIn              (srqIn),
      .response           (response),
      .pollByte           (pollByte),
      .pollByteValid      (pollByteValid),
      .srqOut             (srqOut),
      .srqOe_n            (srqOe_n),
      .clearEvents        (clearEvents),
      .presetEnables      (presetEnables),
      .requestEnableMask  (requestEnableMask),
      .masterSummaryValue (masterSummaryValue),
      .requestServiceFlag (requestServiceFlag),
      .srqLineSeen        (srqLineSeen)
   );
   ssr_bus_ctrl i_ssr_bus_ctrl (
      .clk     (clk),
      .srqOut  (srqOut),
      .srqOe_n (srqOe_n),
      .poll    (poll),
      .srqIn   (srqIn)
   );
   task automatic final_report();
      if (fail_count == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // one cycle gap between commands keeps each strobe a clean pulse
   task automatic send(input ssr_cmd_e c, input logic [7:0] d, input ssr_fmt_e f);
      @(negedge clk);
      cmd = '{1'h1, c, d, f};
      @(negedge clk);
      cmd = '0;
   endtask
   task automatic query(input ssr_cmd_e c, input logic [7:0] e);
      send(c, 8'h00, FMT_DEC);
      `CHK("valid", 1'h1, response.valid)
      `CHK("data", e, response.data)
   endtask
   initial begin
      repeat (4) @(negedge clk);
      nrst = 1'h1;
      query(CMD_SRE_QUERY, 8'h00);
      `CHK("fmt", FMT_DEC, response.fmt)
      foreach (wv[i]) begin
         send(CMD_SRE_WRITE, wv[i], FMT_DEC);
         query(CMD_SRE_QUERY, wv[i]);
      end
      summary = 6'h3F;
      send(CMD_SRE_WRITE, 8'h42, FMT_DEC);
      query(CMD_STB_QUERY, 8'hBD);
      `CHK("flag", 1'h0, requestServiceFlag)
      summary = 6'h00;
      send(CMD_CLEAR_STATUS, 8'h00, FMT_DEC);
      `CHK("clear", 1'h1, clearEvents)
      send(CMD_STATUS_PRESET, 8'h00, FMT_DEC);
      `CHK("preset", 1'h1, presetEnables)
      query(CMD_SRE_QUERY, 8'h42);
      for (int f = 0; f < 4; f++) begin
         send(CMD_FORMAT_SET, 8'h00, ssr_fmt_e'(f));
         query(CMD_SRE_QUERY, 8'h42);
         `CHK("fmt", f[1:0], response.fmt)
      end
      for (int k = 0; k < 6; k++) begin
         send(CMD_SRE_WRITE, bitv[k], FMT_DEC);
         summary = 6'h01 << k;
         @(negedge clk);
         `CHK("flag", 1'h1, requestServiceFlag)
         `CHK("line", 1'h0, srqIn)
         `CHK("drive", 1'h0, srqOut)
         query(CMD_STB_QUERY, bitv[k] | 8'h40);
         i_ssr_bus_ctrl.talk_byte();
         `CHK("pvalid", 1'h1, pollByteValid)
         `CHK("pbyte", bitv[k] | 8'h40, pollByte)
         `CHK("flag", 1'h0, requestServiceFlag)
         `CHK("release", 1'h1, srqIn)
         `CHK("seen", 1'h1, srqLineSeen)
         i_ssr_bus_ctrl.stop_poll();
         query(CMD_STB_QUERY, bitv[k] | 8'h40);
         `CHK("unseen", 1'h0, srqLineSeen)
         occurred = summary;
         @(negedge clk);
         occurred = 6'h00;
         `CHK("again", 1'h1, requestServiceFlag)
         i_ssr_bus_ctrl.talk_byte();
         i_ssr_bus_ctrl.stop_poll();
         summary = 6'h00;
         query(CMD_STB_QUERY, 8'h00);
      end
      i_ssr_bus_ctrl.talk_byte();
      `CHK("idle poll", 8'h00, pollByte)
      final_report();
   end
   initial begin
      #(50 * 3000);
      fail_count++;
      final_report();
   end
endmodule
